// [hdl/mmm_pkg.sv]
// Shared constants of the machine I/O message mapper: sizes, register map,
// field positions, reset values, codes and timing.
// Assumes a 100 MHz APB clock and loop currents given in microamps.
package mmm_pkg;

  // Sizes of the block.
  localparam int NUM_STATE = 11;
  localparam int NUM_OUT = 8;
  localparam int NUM_IN = 16;
  localparam int NUM_AIN = 8;
  localparam int NUM_SLOT = 6;
  localparam int NUM_CHAN = 6;

  // Bit positions of the machine states on the state input.
  localparam int ST_POWERED = 0;
  localparam int ST_GROUP_ALARM = 1;
  localparam int ST_MOTOR_RUN = 2;
  localparam int ST_MACHINE_ON = 3;
  localparam int ST_GROUP_WARN = 4;
  localparam int ST_REMOTE = 5;
  localparam int ST_IDLE = 6;
  localparam int ST_LOAD = 7;
  localparam int ST_CLOCK_ACT = 8;
  localparam int ST_CLOCK_CONTACT = 9;
  localparam int ST_ESTOP = 10;

  // Register byte offsets; bits 8:6 pick the group, bits 5:2 the entry.
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_EDIT = 12'h004;
  localparam logic [11:0] OFS_OUTMAP = 12'h040;
  localparam logic [11:0] OFS_SLOTCFG = 12'h080;
  localparam logic [11:0] OFS_SLOTSCALE = 12'h0c0;
  localparam logic [11:0] OFS_SLOTLABEL = 12'h100;
  localparam logic [11:0] OFS_CHCFG = 12'h140;

  // Status register fields.
  localparam int STS_ALARM_BIT = 16;
  localparam int STS_REFUSED_BIT = 17;
  localparam int STS_ACTIVE_LSB = 18;
  // Edit register fields.
  localparam int ED_EN_BIT = 0;
  localparam int ED_SLOT_LSB = 1;
  localparam int ED_TOP_BIT = 4;
  localparam int ED_EXP_LSB = 6;
  // Slot configuration fields.
  localparam int SC_TYPE_BIT = 0;
  localparam int SC_SEL_LSB = 4;
  localparam int SC_VAL_LSB = 16;
  // Channel configuration fields.
  localparam int CH_CLASS_LSB = 0;
  localparam int CH_POL_BIT = 2;
  localparam int CH_SEL_LSB = 3;
  localparam int CH_DLY_LSB = 16;

  // Message classes.
  localparam logic [1:0] CLASS_OP = 2'h0;
  localparam logic [1:0] CLASS_WARN = 2'h1;
  localparam logic [1:0] CLASS_ALARM = 2'h2;

  // Loop types: 0 means 4-20 mA, 1 means 0-20 mA.
  localparam logic LOOP_4_20 = 1'b0;
  localparam logic [15:0] CUR_4MA_UA = 16'h0fa0;
  localparam logic [15:0] SPAN_4_20_UA = 16'h3e80;
  localparam logic [15:0] SPAN_0_20_UA = 16'h4e20;

  // Reset values and limits.
  localparam logic [15:0] SCALE_TOP_RST = 16'h2710;
  localparam logic [15:0] SCALE_BOT_RST = 16'h0000;
  localparam logic [15:0] DLY_MIN = 16'h0001;
  localparam logic [15:0] DLY_MAX = 16'hea60;
  localparam logic [3:0] SRC_MAX = 4'hb;
  localparam logic [3:0] CHAR_LAST = 4'he;
  localparam logic [3:0] STEP_REPEATS = 4'ha;
  localparam logic [1:0] STEP_EXP_MAX = 2'h3;

  // Timing: debounce unit and key repeat period.
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEB_STEP_NS = 10_000_000;
  localparam int TICK_CYC = DEB_STEP_NS / CLK_PERIOD_NS;
  localparam int KEY_REPEAT_NS = 200_000_000;
  localparam int KEY_REPEAT_CYC = KEY_REPEAT_NS / CLK_PERIOD_NS;

  // Step size for a given growth stage: units, tens, hundreds, thousands.
  function automatic logic [15:0] step_of(input logic [1:0] exp);
    logic [15:0] s;
    unique case (exp)
      2'h0: s = 16'h0001;
      2'h1: s = 16'h000a;
      2'h2: s = 16'h0064;
      2'h3: s = 16'h03e8;
    endcase
    return s;
  endfunction

endpackage

// [hdl/mmm_debounce.sv]
// Debounce timer of one external message channel.
// Assumes a one-cycle tick per debounce unit and a level already synchronised.
`timescale 1ns/100ps
module mmm_debounce (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Timing and level.
  input wire logic tick,
  input wire logic enable,
  input wire logic trig,
  input wire logic [15:0] delay,
  // Debounced message.
  output logic active
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // Whole state of the timer.
  typedef struct packed {
    logic [15:0] cnt;
    logic active;
  } mmm_deb_s;

  mmm_deb_s st;
  mmm_deb_s next_st;

  // Counts units while the level persists and drops at once when it goes.
  always_comb begin
    next_st = st;
    if (!enable || !trig) begin
      // A lost level restarts the timing from zero.
      next_st.cnt = 16'h0000;
      next_st.active = 1'b0;
    end else if (!st.active && tick) begin
      // The message stands only after the full delay.
      next_st.cnt = st.cnt + 16'h0001;
      if (st.cnt + 16'h0001 >= delay) begin
        next_st.active = 1'b1;
      end
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.active;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_drop_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !trig |=> !active && st.cnt == 16'h0000) else $error("Lost level did not clear timer.");

  a_delay_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(active) |-> st.cnt >= delay && $past(trig)) else $error("Message rose before delay.");

endmodule

// [hdl/mmm_top.sv]
// Machine I/O message mapper: routes machine states to relay outputs,
// scales analog loop slots and debounces six external message channels.
// Assumes an APB master on pclk, same-clock machine states and analog values,
// and asynchronous binary input and key pins.
//
// Summary of operation
// - Eleven machine states offered for output routing.
// - One source per output; busy output refuses.
// - Bound output follows its chosen state.
// - Six analog display slots available.
// - Slot loop type 4-20 or 0-20, default 4-20.
// - Linear scaling, configurable ends, default 0-10000.
// - Held key grows step: units to thousands.
// - Slot bound to input shows scaled value.
// - Label characters from a fifteen-symbol set.
// - Six external message channels, zero to five.
// - Channel class alarm, warning or operational.
// - Alarm-class message shuts machine down.
// - Each channel evaluates its chosen binary input.
// - Polarity: high or low level triggers.
// - Level must persist for the delay.
// - Delay 0.01 s to 600 s, 0.01 s steps.
`timescale 1ns/100ps
module mmm_top #(
  parameter int TICK_CYC = mmm_pkg::TICK_CYC,
  parameter int KEY_REPEAT_CYC = mmm_pkg::KEY_REPEAT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Machine side.
  input wire logic [mmm_pkg::NUM_STATE-1:0] machine_state,
  input wire logic [mmm_pkg::NUM_AIN*16-1:0] analog_ua,
  input wire logic [mmm_pkg::NUM_IN-1:0] binary_in,
  input wire logic key_up,
  input wire logic key_down,
  // Results.
  output logic [mmm_pkg::NUM_OUT-1:0] relay_out,
  output logic msg_alarm,
  output logic msg_warning,
  output logic msg_operational,
  output logic machine_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  localparam int NO = mmm_pkg::NUM_OUT;
  localparam int NS = mmm_pkg::NUM_SLOT;
  localparam int NC = mmm_pkg::NUM_CHAN;

  // Whole state of the block.
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [mmm_pkg::NUM_IN-1:0] bin_s1;
    logic [mmm_pkg::NUM_IN-1:0] bin_s2;
    logic [1:0] key_s1;
    logic [1:0] key_s2;
    logic [NO-1:0][3:0] out_src;
    logic [NO-1:0] relay;
    logic [NS-1:0] slot_type;
    logic [NS-1:0][3:0] slot_sel;
    logic [NS-1:0][15:0] scale_top;
    logic [NS-1:0][15:0] scale_bot;
    logic [NS-1:0][15:0] slot_val;
    logic [NS-1:0][31:0] label;
    logic [NC-1:0][1:0] ch_class;
    logic [NC-1:0] ch_pol;
    logic [NC-1:0][4:0] ch_sel;
    logic [NC-1:0][15:0] ch_dly;
    logic alarm_latched;
    logic refused;
    logic msg_alarm;
    logic msg_warn;
    logic msg_op;
    logic edit_en;
    logic [2:0] edit_slot;
    logic edit_top;
    logic [1:0] step_exp;
    logic [3:0] rep_cnt;
    logic [31:0] key_cnt;
    logic [31:0] tick_cnt;
    logic tick;
  } mmm_top_s;

  // Reset image: top of range 10000, bottom 0, shortest delay.
  function automatic mmm_top_s rst_value();
    mmm_top_s r;
    r = '0;
    for (int i = 0; i < NS; i++) begin
      r.scale_top[i] = mmm_pkg::SCALE_TOP_RST;
      r.scale_bot[i] = mmm_pkg::SCALE_BOT_RST;
      r.slot_type[i] = mmm_pkg::LOOP_4_20;
    end
    for (int i = 0; i < NC; i++) begin
      r.ch_dly[i] = mmm_pkg::DLY_MIN;
    end
    return r;
  endfunction

  localparam mmm_top_s RST_ST = rst_value();

  // Linear map of a loop current onto the slot's quantity range.
  function automatic logic [15:0] scale(input logic [15:0] cur, input logic typ,
                                        input logic [15:0] top, input logic [15:0] bot);
    logic [15:0] base;
    logic [15:0] span;
    logic [15:0] off;
    logic signed [33:0] prod;
    logic signed [33:0] sum;
    base = (typ == mmm_pkg::LOOP_4_20) ? mmm_pkg::CUR_4MA_UA : 16'h0000;
    span = (typ == mmm_pkg::LOOP_4_20) ? mmm_pkg::SPAN_4_20_UA : mmm_pkg::SPAN_0_20_UA;
    off = (cur < base) ? 16'h0000 : cur - base;
    if (off > span) begin
      off = span;
    end
    prod = 34'(signed'({1'b0, top}) - signed'({1'b0, bot})) * signed'({18'h00000, off});
    sum = prod / signed'({18'h00000, span}) + signed'({18'h00000, bot});
    return sum[15:0];
  endfunction

  mmm_top_s st;
  mmm_top_s next_st;
  logic [NC-1:0] ch_trig;
  logic [NC-1:0] ch_en;
  logic [NC-1:0] ch_active;
  logic held;
  logic hit;
  logic wr;
  logic [2:0] region;
  int idx;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Computes every next value of the block in one pass.
  always_comb begin
    logic [15:0] cur;
    logic [15:0] step;
    logic [15:0] old;
    logic [16:0] up_sum;
    logic [31:0] rd;
    logic any_a;
    logic any_w;
    logic any_o;
    int s;
    cur = 16'h0000;
    step = 16'h0000;
    old = 16'h0000;
    up_sum = 17'h00000;
    rd = 32'h0000_0000;
    any_a = 1'b0;
    any_w = 1'b0;
    any_o = 1'b0;
    s = 0;
    next_st = st;
    region = paddr[8:6];
    idx = int'(paddr[5:2]);
    wr = psel && penable && st.pready && pwrite;
    held = st.edit_en && (st.key_s2[0] != st.key_s2[1]);

    // Pin synchronisers.
    next_st.bin_s1 = binary_in;
    next_st.bin_s2 = st.bin_s1;
    next_st.key_s1 = {key_down, key_up};
    next_st.key_s2 = st.key_s1;

    // Debounce unit tick.
    next_st.tick = (st.tick_cnt == 32'(TICK_CYC - 1));
    next_st.tick_cnt = next_st.tick ? 32'h0000_0000 : st.tick_cnt + 32'h0000_0001;

    // Relays follow their bound state; unbound or bad sources stay open.
    for (int k = 0; k < NO; k++) begin
      s = int'(st.out_src[k]);
      next_st.relay[k] = (s != 0 && s <= mmm_pkg::NUM_STATE) ? machine_state[s-1] : 1'b0;
    end

    // Slots show the scaled value of their bound input, else zero.
    for (int i = 0; i < NS; i++) begin
      s = int'(st.slot_sel[i]);
      cur = (s != 0 && s <= mmm_pkg::NUM_AIN) ? analog_ua[(s-1)*16 +: 16] : 16'h0000;
      next_st.slot_val[i] = (s != 0 && s <= mmm_pkg::NUM_AIN) ?
                            scale(cur, st.slot_type[i], st.scale_top[i], st.scale_bot[i]) : 16'h0000;
    end

    // Held key adjusts the chosen scale end with a growing step.
    if (held && int'(st.edit_slot) < NS) begin
      if (st.key_cnt == 32'h0000_0000) begin
        step = mmm_pkg::step_of(st.step_exp);
        old = st.edit_top ? st.scale_top[st.edit_slot] : st.scale_bot[st.edit_slot];
        up_sum = {1'b0, old} + {1'b0, step};
        if (st.key_s2[0]) begin
          old = up_sum[16] ? 16'hffff : up_sum[15:0];
        end else begin
          old = (old < step) ? 16'h0000 : old - step;
        end
        if (st.edit_top) begin
          next_st.scale_top[st.edit_slot] = old;
        end else begin
          next_st.scale_bot[st.edit_slot] = old;
        end
        next_st.key_cnt = 32'(KEY_REPEAT_CYC - 1);
        // After a run of repeats the step grows one decade.
        if (st.rep_cnt == mmm_pkg::STEP_REPEATS - 4'h1) begin
          next_st.rep_cnt = 4'h0;
          if (st.step_exp != mmm_pkg::STEP_EXP_MAX) begin
            next_st.step_exp = st.step_exp + 2'h1;
          end
        end else begin
          next_st.rep_cnt = st.rep_cnt + 4'h1;
        end
      end else begin
        next_st.key_cnt = st.key_cnt - 32'h0000_0001;
      end
    end else begin
      // Release restarts at unit steps with an immediate first step.
      next_st.key_cnt = 32'h0000_0000;
      next_st.rep_cnt = 4'h0;
      next_st.step_exp = 2'h0;
    end

    // Channel levels: chosen input, polarity applied.
    for (int c = 0; c < NC; c++) begin
      s = int'(st.ch_sel[c]);
      ch_en[c] = (s != 0 && s <= mmm_pkg::NUM_IN);
      ch_trig[c] = ch_en[c] ? (st.bin_s2[s-1] == st.ch_pol[c]) : 1'b0;
    end

    // Debounced messages reported under their class.
    for (int c = 0; c < NC; c++) begin
      any_a = any_a || (ch_active[c] && st.ch_class[c] == mmm_pkg::CLASS_ALARM);
      any_w = any_w || (ch_active[c] && st.ch_class[c] == mmm_pkg::CLASS_WARN);
      any_o = any_o || (ch_active[c] && st.ch_class[c] == mmm_pkg::CLASS_OP);
    end
    next_st.msg_alarm = any_a;
    next_st.msg_warn = any_w;
    next_st.msg_op = any_o;

    // Address decode.
    unique case (region)
      mmm_pkg::OFS_STATUS[8:6]: hit = (idx < 2);
      mmm_pkg::OFS_OUTMAP[8:6]: hit = (idx < NO);
      mmm_pkg::OFS_SLOTCFG[8:6], mmm_pkg::OFS_SLOTSCALE[8:6], mmm_pkg::OFS_SLOTLABEL[8:6]: hit = (idx < NS);
      mmm_pkg::OFS_CHCFG[8:6]: hit = (idx < NC);
      default: hit = 1'b0;
    endcase
    hit = hit && (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0);

    // Register writes at the completing access edge.
    if (wr && hit) begin
      unique case (region)
        mmm_pkg::OFS_STATUS[8:6]: begin
          if (paddr == mmm_pkg::OFS_EDIT) begin
            next_st.edit_en = pwdata[mmm_pkg::ED_EN_BIT];
            next_st.edit_slot = pwdata[mmm_pkg::ED_SLOT_LSB +: 3];
            next_st.edit_top = pwdata[mmm_pkg::ED_TOP_BIT];
          end else begin
            if (pwdata[mmm_pkg::STS_ALARM_BIT]) begin
              next_st.alarm_latched = 1'b0;
            end
            if (pwdata[mmm_pkg::STS_REFUSED_BIT]) begin
              next_st.refused = 1'b0;
            end
          end
        end
        mmm_pkg::OFS_OUTMAP[8:6]: begin
          // A busy output or an unknown source refuses the binding.
          if (pwdata[3:0] == 4'h0) begin
            next_st.out_src[idx] = 4'h0;
          end else if (st.out_src[idx] != 4'h0 || pwdata[3:0] > mmm_pkg::SRC_MAX) begin
            next_st.refused = 1'b1;
          end else begin
            next_st.out_src[idx] = pwdata[3:0];
          end
        end
        mmm_pkg::OFS_SLOTCFG[8:6]: begin
          next_st.slot_type[idx] = pwdata[mmm_pkg::SC_TYPE_BIT];
          next_st.slot_sel[idx] = pwdata[mmm_pkg::SC_SEL_LSB +: 4];
        end
        mmm_pkg::OFS_SLOTSCALE[8:6]: begin
          next_st.scale_bot[idx] = pwdata[15:0];
          next_st.scale_top[idx] = pwdata[31:16];
        end
        mmm_pkg::OFS_SLOTLABEL[8:6]: begin
          // Only the fifteen defined characters are stored.
          for (int j = 0; j < 8; j++) begin
            if (pwdata[j*4 +: 4] <= mmm_pkg::CHAR_LAST) begin
              next_st.label[idx][j*4 +: 4] = pwdata[j*4 +: 4];
            end
          end
        end
        mmm_pkg::OFS_CHCFG[8:6]: begin
          next_st.ch_class[idx] = pwdata[mmm_pkg::CH_CLASS_LSB +: 2];
          next_st.ch_pol[idx] = pwdata[mmm_pkg::CH_POL_BIT];
          next_st.ch_sel[idx] = pwdata[mmm_pkg::CH_SEL_LSB +: 5];
          // Delay held within 1 to 60000 units of 10 ms.
          if (pwdata[mmm_pkg::CH_DLY_LSB +: 16] < mmm_pkg::DLY_MIN) begin
            next_st.ch_dly[idx] = mmm_pkg::DLY_MIN;
          end else if (pwdata[mmm_pkg::CH_DLY_LSB +: 16] > mmm_pkg::DLY_MAX) begin
            next_st.ch_dly[idx] = mmm_pkg::DLY_MAX;
          end else begin
            next_st.ch_dly[idx] = pwdata[mmm_pkg::CH_DLY_LSB +: 16];
          end
        end
        default: begin
        end
      endcase
    end

    // An alarm message latches the shutdown; the set beats a clear.
    if (any_a) begin
      next_st.alarm_latched = 1'b1;
    end

    // Read data is prepared in the setup cycle and answered one cycle later.
    unique case (region)
      mmm_pkg::OFS_STATUS[8:6]: begin
        if (paddr[2]) begin
          rd[mmm_pkg::ED_EN_BIT] = st.edit_en;
          rd[mmm_pkg::ED_SLOT_LSB +: 3] = st.edit_slot;
          rd[mmm_pkg::ED_TOP_BIT] = st.edit_top;
          rd[mmm_pkg::ED_EXP_LSB +: 2] = st.step_exp;
        end else begin
          rd[mmm_pkg::NUM_STATE-1:0] = machine_state;
          rd[mmm_pkg::STS_ALARM_BIT] = st.alarm_latched;
          rd[mmm_pkg::STS_REFUSED_BIT] = st.refused;
          rd[mmm_pkg::STS_ACTIVE_LSB +: NC] = ch_active;
        end
      end
      mmm_pkg::OFS_OUTMAP[8:6]: rd[3:0] = st.out_src[idx];
      mmm_pkg::OFS_SLOTCFG[8:6]: begin
        rd[mmm_pkg::SC_TYPE_BIT] = st.slot_type[idx];
        rd[mmm_pkg::SC_SEL_LSB +: 4] = st.slot_sel[idx];
        rd[mmm_pkg::SC_VAL_LSB +: 16] = st.slot_val[idx];
      end
      mmm_pkg::OFS_SLOTSCALE[8:6]: rd = {st.scale_top[idx], st.scale_bot[idx]};
      mmm_pkg::OFS_SLOTLABEL[8:6]: rd = st.label[idx];
      mmm_pkg::OFS_CHCFG[8:6]: begin
        rd[mmm_pkg::CH_CLASS_LSB +: 2] = st.ch_class[idx];
        rd[mmm_pkg::CH_POL_BIT] = st.ch_pol[idx];
        rd[mmm_pkg::CH_SEL_LSB +: 5] = st.ch_sel[idx];
        rd[mmm_pkg::CH_DLY_LSB +: 16] = st.ch_dly[idx];
      end
      default: rd = 32'h0000_0000;
    endcase
    next_st.pready = psel && !penable;
    if (psel && !penable) begin
      next_st.prdata = hit ? rd : 32'h0000_0000;
      next_st.pslverr = !hit;
    end
  end

  // Registers the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel timers and outputs.

  // One debounce timer per external message channel.
  for (genvar c = 0; c < NC; c++) begin : g_chan
    mmm_debounce u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .tick(st.tick),
      .enable(ch_en[c]),
      .trig(ch_trig[c]),
      .delay(st.ch_dly[c]),
      .active(ch_active[c])
    );
  end

  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign relay_out = st.relay;
  assign msg_alarm = st.msg_alarm;
  assign msg_warning = st.msg_warn;
  assign msg_operational = st.msg_op;
  assign machine_shutdown = st.alarm_latched;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("Ready not a single access cycle.");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !hit |=> pslverr && prdata == 32'h0000_0000) else $error("Unmapped address not flagged.");

  a_refuse_busy: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == mmm_pkg::OFS_OUTMAP && pwdata[3:0] != 4'h0 && st.out_src[0] != 4'h0
    |=> $stable(st.out_src[0]) && st.refused) else $error("Busy output accepted a binding.");

  a_relay_follows: assert property (@(posedge pclk) disable iff (!presetn)
    st.out_src[0] == 4'h1 ##1 st.out_src[0] == 4'h1 |-> relay_out[0] == $past(machine_state[0]))
    else $error("Relay does not follow its state.");

  a_unbound_open: assert property (@(posedge pclk) disable iff (!presetn)
    st.out_src[1] == 4'h0 |=> !relay_out[1]) else $error("Unbound relay driven.");

  a_alarm_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
    ch_active[2] && st.ch_class[2] == mmm_pkg::CLASS_ALARM |=> msg_alarm && machine_shutdown)
    else $error("Alarm message did not shut down.");

  a_shutdown_holds: assert property (@(posedge pclk) disable iff (!presetn)
    machine_shutdown && !(wr && paddr == mmm_pkg::OFS_STATUS) |=> machine_shutdown)
    else $error("Shutdown dropped without clear.");

  a_step_grows: assert property (@(posedge pclk) disable iff (!presetn)
    held && $past(held) |-> st.step_exp >= $past(st.step_exp)) else $error("Step shrank while key held.");

  a_unbound_chan: assert property (@(posedge pclk) disable iff (!presetn)
    st.ch_sel[0] == 5'h00 ##1 st.ch_sel[0] == 5'h00 |-> !ch_active[0]) else $error("Unbound channel raised.");

  a_delay_range: assert property (@(posedge pclk) disable iff (!presetn)
    st.ch_dly[0] >= mmm_pkg::DLY_MIN && st.ch_dly[0] <= mmm_pkg::DLY_MAX) else $error("Delay out of range.");

endmodule

// [verif/mmm_contacts.sv]
// Model of the machine contacts wired to the binary input pins.
// Assumes the bench sets the wanted contact levels after a clock edge.
`timescale 1ns/100ps
module mmm_contacts (
  // Clock.
  input wire logic pclk,
  // Wanted levels and driven pins.
  input wire logic [15:0] want,
  output logic [15:0] pins
);
  // Contacts settle one cycle after the bench asks, as a relay would.
  always @(posedge pclk) begin
    pins <= want;
  end
endmodule

// [verif/test_machine_io_message_mapper.sv]
// Bench of the message mapper: APB master, routing, scaling and channels.
// Assumes short tick and key repeat counts for a quick run.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("BAD %0t %h %h", $time, g, e); end end
module test_machine_io_message_mapper;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, shut, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [10:0] mstate = 0;
  logic [127:0] ain = 0;
  logic [15:0] want = 16'h0001, bin;
  logic [7:0] relay;
  logic [2:0] msg;
  logic [1:0] key = 2'h0;
  int err_count = 0, checks_done = 0, seed = 32'h16fb, n, k, v;
  // Free running 100 MHz clock.
  always #5 pclk = ~pclk;
  mmm_contacts PM (.pclk(pclk), .want(want), .pins(bin));
  mmm_top #(.TICK_CYC(4), .KEY_REPEAT_CYC(3)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .machine_state(mstate), .analog_ua(ain), .binary_in(bin), .key_up(key[0]),
    .key_down(key[1]), .relay_out(relay), .msg_alarm(msg[2]), .msg_warning(msg[1]),
    .msg_operational(msg[0]), .machine_shutdown(shut));
  // Prints the counts and the verdict, then stops.
  task close_out;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; read data and error land in rd and er.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      err_count++;
      close_out;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Reference scaling of a loop current in microamps.
  function automatic int scl(int cur, int typ, int top, int bot);
    int off, span;
    span = typ ? 20000 : 16000;
    off = typ ? cur : cur - 4000;
    if (off < 0) off = 0;
    if (off > span) off = span;
    return bot + (top - bot) * off / span;
  endfunction
  // Main sequence.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h0c0, 0);
    `CHK(rd, 32'h27100000)
    apb(0, 12'h080, 0);
    `CHK(rd[0], 1'b0)
    apb(0, 12'h200, 0);
    `CHK(er, 1'b1) // Unmapped place answers with an error.
    apb(0, 12'h094, 0);
    `CHK(er, 1'b0)
    apb(0, 12'h098, 0);
    `CHK(er, 1'b1)
    apb(1, 12'h100, 32'hf0123456);
    apb(0, 12'h100, 0);
    `CHK(rd, 32'h00123456)
    apb(1, 12'h14c, 32'hffff0000);
    apb(0, 12'h14c, 0);
    `CHK(rd[31:16], 16'(600 * 100))
    for (k = 0; k < 8; k++) apb(1, 12'h040 + 12'(4 * k), 32'(k + 1));
    repeat (4) begin
      mstate <= 11'($random(seed));
      repeat (3) @(posedge pclk);
      `CHK(relay, mstate[7:0])
    end
    apb(1, 12'h044, 5);
    apb(0, 12'h000, 0);
    `CHK(rd[17], 1'b1)
    apb(1, 12'h040, 0);
    repeat (3) @(posedge pclk);
    `CHK(relay[0], 1'b0)
    apb(1, 12'h040, 11);
    mstate <= 11'h400;
    repeat (3) @(posedge pclk);
    `CHK(relay[0], 1'b1)
    apb(1, 12'h0c0, 32'h03e80064);
    for (k = 0; k < 2; k++) begin
      v = 4000 + ($random(seed) & 32'h3fff);
      ain[15:0] <= 16'(v);
      apb(1, 12'h080, 32'(16 + k));
      apb(0, 12'h080, 0);
      `CHK(rd[31:16], 16'(scl(v, k, 1000, 100)))
    end
    // Hold up, then down, on the top of slot 0: ten unit steps, ten tens and five hundreds.
    apb(1, 12'h004, 32'h00000011);
    for (k = 0; k < 2; k++) begin
      key[k] <= 1'b1;
      repeat (75) @(posedge pclk);
      key[k] <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(0, 12'h0c0, 0);
      `CHK(rd[31:16], 16'(k ? 1000 : 1000 + 10 * 1 + 10 * 10 + 5 * 100))
    end
    apb(1, 12'h140, 32'h00020008);
    apb(1, 12'h144, 32'h00020015);
    apb(1, 12'h148, 32'h0002001e);
    // Short pulses must not add up across a gap.
    repeat (2) begin
      want[1] <= 1;
      repeat (3) @(posedge pclk);
      want[1] <= 0;
      repeat (12) @(posedge pclk);
    end
    `CHK(msg, 3'h0)
    for (k = 0; k < 3; k++) begin
      want[k] <= ~want[k];
      repeat (4) @(posedge pclk);
      `CHK(msg[k], 1'b0)
      n = 0;
      while (msg[k] !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 40) begin
        err_count++;
        close_out;
      end
      @(posedge pclk);
      `CHK(msg[k], 1'b1)
      `CHK(shut, 1'(k == 2))
    end
    apb(0, 12'h000, 0);
    `CHK(rd[23:18], 6'h07)
    close_out;
  end
endmodule
